// ### design/timer8_pkg.sv
// Purpose: shared constants and types for the 8-bit timer with compare unit
// Assumes: 32-bit APB, one aligned word per register
// Notes:   offsets are byte addresses
package timer8_pkg;

    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_COUNT  = 8'h04;
    localparam logic [7:0] OFS_CMP    = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] OFS_IRQEN  = 8'h10;
    localparam logic [7:0] OFS_PORT   = 8'h14;

    // control register fields
    localparam int CTRL_CS_LSB  = 0;
    localparam int CTRL_WGM_LSB = 3;
    localparam int CTRL_COM_LSB = 5;
    localparam int CTRL_FOC_BIT = 7;

    // flag register fields
    localparam int FLG_OVF_BIT = 0;
    localparam int FLG_CMP_BIT = 1;

    // port register fields
    localparam int PORT_OUT_BIT = 0;
    localparam int PORT_DIR_BIT = 1;

    localparam logic [2:0] CS_RESET  = 3'h0;
    localparam logic [1:0] COM_RESET = 2'h0;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'h0,
        WGM_PC_PWM = 2'h1,
        WGM_CTC    = 2'h2,
        WGM_FAST   = 2'h3
    } wgm_t;

    typedef struct packed {
        logic [2:0] cs;
        wgm_t       wgm;
        logic [1:0] com;
    } ctrl_t;

    typedef struct packed {
        logic top;
        logic bottom;
        logic match;
        logic dir_down;
    } cnt_stat_t;

endpackage

// ### design/timer8_counter.sv
// Purpose: 8-bit bidirectional counter with direction output
// Assumes: tick is a one-cycle enable pulse
// Notes:   software write beats any count operation
`timescale 1ns/1ns
module timer8_counter
    import timer8_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       tick_i,
    input  wire wgm_t       wgm_i,
    input  wire logic [7:0] cmp_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] count_o,
    output logic            down_o
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic       down_r;
    logic       down_nxt;
    wire        at_max = (count_r == CNT_MAX);
    wire        at_bot = (count_r == CNT_BOTTOM);

    always_comb begin
        count_nxt = count_r;
        down_nxt  = down_r;
        if (tick_i) begin
            case (wgm_i)
                WGM_CTC: begin
                    count_nxt = (count_r == cmp_i) ? CNT_BOTTOM : count_r + 8'h01;
                end
                WGM_PC_PWM: begin
                    if (at_max) begin
                        down_nxt  = 1'b1;
                        count_nxt = count_r - 8'h01;
                    end else if (at_bot) begin
                        down_nxt  = 1'b0;
                        count_nxt = count_r + 8'h01;
                    end else begin
                        count_nxt = down_r ? count_r - 8'h01 : count_r + 8'h01;
                    end
                end
                default: begin
                    down_nxt  = 1'b0;
                    count_nxt = count_r + 8'h01;
                end
            endcase
        end
        if (wr_i) begin
            count_nxt = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count_r <= CNT_BOTTOM;
            down_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            down_r  <= down_nxt;
        end
    end

    assign count_o = count_r;
    assign down_o  = down_r;
endmodule

// ### design/timer8_wavegen.sv
// Purpose: compare output state from match, mode and output action
// Assumes: match_i already qualified by tick and blocking
// Notes:   state survives mode changes
`timescale 1ns/1ns
module timer8_wavegen
    import timer8_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       tick_i,
    input  wire wgm_t       wgm_i,
    input  wire logic [1:0] com_i,
    input  wire logic       match_i,
    input  wire logic       force_i,
    input  wire logic       down_i,
    input  wire logic [7:0] count_i,
    input  wire logic [7:0] cmp_i,
    output logic            oc_o
);
    logic oc_r;
    logic oc_nxt;
    wire  is_pwm   = (wgm_i == WGM_FAST) || (wgm_i == WGM_PC_PWM);
    wire  inv      = com_i[0];
    wire  at_max   = (count_i == CNT_MAX);
    wire  at_bot   = (count_i == CNT_BOTTOM);
    // fast pwm: restart from bottom, unless compare at max keeps it steady
    wire  fast_rst = tick_i && at_max && (cmp_i != CNT_MAX);

    always_comb begin
        oc_nxt = oc_r;
        if (com_i != 2'h0) begin
            if (!is_pwm) begin
                if (match_i || force_i) begin
                    case (com_i)
                        2'h1:    oc_nxt = ~oc_r;
                        2'h2:    oc_nxt = 1'b0;
                        default: oc_nxt = 1'b1;
                    endcase
                end
            end else if (com_i[1]) begin
                if (wgm_i == WGM_FAST) begin
                    if (match_i) begin
                        oc_nxt = ~inv ^ 1'b1;
                    end else if (fast_rst) begin
                        oc_nxt = ~inv;
                    end
                end else if (match_i) begin
                    oc_nxt = down_i ? ~inv : inv;
                end else if (tick_i && at_max && (cmp_i == CNT_MAX)) begin
                    oc_nxt = inv;
                end else if (tick_i && at_bot && (cmp_i == CNT_BOTTOM)) begin
                    oc_nxt = ~inv;
                end
            end else if (wgm_i == WGM_FAST && match_i) begin
                oc_nxt = ~oc_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            oc_r <= 1'b0;
        end else begin
            oc_r <= oc_nxt;
        end
    end

    assign oc_o = oc_r;
endmodule

// ### design/timer8_top.sv
// Purpose: 8-bit timer counter with one compare channel behind APB
// Assumes: tick pulse is synchronous to CLK_I; no prescaler inside
// Notes:   compare buffer active only in pwm modes
//
// How it works
// - each tick clears, increments or decrements counter
// - source select zero stops all ticks
// - counter readable and writable at any time
// - counter write beats tick operation
// - top and bottom indications drive waveform
// - two mode bits select counting sequence
// - overflow flag set per mode
// - comparator checks counter against compare value
// - match flag set one tick later
// - enable bit gates match flag to irq
// - flag clears on service or write one
// - waveform uses match, mode, action, extremes
// - compare buffered only in pwm modes
// - buffer loads at top or bottom
// - software reaches buffer or active value
// - force strobe acts like match, non-pwm
// - counter write blocks next tick match
// - output state kept across mode change
// - nonzero action overrides port output
// - action zero leaves output unchanged
// - action bits not buffered
// - mode codes normal, pc pwm, ctc, fast
// - max all ones, bottom zero
`timescale 1ns/1ns
module timer8_top
    import timer8_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        TICK_I,
    input  wire logic        OVF_ACK_I,
    input  wire logic        CMP_ACK_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             PIN_OUT_O,
    output logic             PIN_OE_O,
    output logic             CLK_SRC_ON_O,
    output logic             OVF_IRQ_O,
    output logic             CMP_IRQ_O
);
    ctrl_t      ctrl_r;
    logic [7:0] cmp_act_r;
    logic [7:0] cmp_buf_r;
    logic       ovf_flag_r;
    logic       cmp_flag_r;
    logic       cmp_irq_en_r;
    logic       ovf_irq_en_r;
    logic       port_out_r;
    logic       port_dir_r;
    logic       block_r;
    logic       pending_r;
    logic [7:0] count;
    logic       down;
    logic       oc_state;
    cnt_stat_t  stat;
    logic [31:0] rdata_r;

    // apb decode, zero wait states
    wire access   = PSEL_I && PENABLE_I;
    wire wr       = access && PWRITE_I;
    wire rd       = access && !PWRITE_I;
    wire sel_ctrl = (PADDR_I == OFS_CTRL);
    wire sel_cnt  = (PADDR_I == OFS_COUNT);
    wire sel_cmp  = (PADDR_I == OFS_CMP);
    wire sel_flg  = (PADDR_I == OFS_FLAGS);
    wire sel_ien  = (PADDR_I == OFS_IRQEN);
    wire sel_port = (PADDR_I == OFS_PORT);
    wire mapped   = sel_ctrl | sel_cnt | sel_cmp | sel_flg | sel_ien | sel_port;
    wire wr_ctrl  = wr && sel_ctrl;
    wire wr_cnt   = wr && sel_cnt;
    wire wr_cmp   = wr && sel_cmp;
    wire wr_flg   = wr && sel_flg;
    wire [7:0] wbyte = PWDATA_I[7:0];

    wire tick     = TICK_I && (ctrl_r.cs != 3'h0);
    wire buffered = (ctrl_r.wgm == WGM_FAST) || (ctrl_r.wgm == WGM_PC_PWM);

    assign stat.top      = (count == CNT_MAX);
    assign stat.bottom   = (count == CNT_BOTTOM);
    assign stat.match    = (count == cmp_act_r);
    assign stat.dir_down = down;

    // match blocked for the tick after a counter write
    wire match_ev = tick && stat.match && !block_r;
    wire force_ev = wr_ctrl && wbyte[CTRL_FOC_BIT] && !buffered;

    wire ovf_ev = tick && ((ctrl_r.wgm == WGM_PC_PWM) ? (stat.bottom && down)
                                                       : stat.top);
    wire load_pt = tick && ((ctrl_r.wgm == WGM_FAST) ? stat.top
                                                      : (stat.top || (stat.bottom && down)));

    timer8_counter u_counter (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .tick_i  (tick),
        .wgm_i   (ctrl_r.wgm),
        .cmp_i   (cmp_act_r),
        .wr_i    (wr_cnt),
        .wdata_i (wbyte),
        .count_o (count),
        .down_o  (down)
    );

    timer8_wavegen u_wavegen (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .tick_i  (tick),
        .wgm_i   (ctrl_r.wgm),
        .com_i   (ctrl_r.com),
        .match_i (match_ev),
        .force_i (force_ev),
        .down_i  (stat.dir_down),
        .count_i (count),
        .cmp_i   (cmp_act_r),
        .oc_o    (oc_state)
    );

    // control and enables
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ctrl_r       <= '{cs: CS_RESET, wgm: WGM_NORMAL, com: COM_RESET};
            cmp_irq_en_r <= 1'b0;
            ovf_irq_en_r <= 1'b0;
            port_out_r   <= 1'b0;
            port_dir_r   <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r.cs  <= wbyte[CTRL_CS_LSB +: 3];
                ctrl_r.wgm <= wgm_t'(wbyte[CTRL_WGM_LSB +: 2]);
                ctrl_r.com <= wbyte[CTRL_COM_LSB +: 2];
            end
            if (wr && sel_ien) begin
                ovf_irq_en_r <= wbyte[FLG_OVF_BIT];
                cmp_irq_en_r <= wbyte[FLG_CMP_BIT];
            end
            if (wr && sel_port) begin
                port_out_r <= wbyte[PORT_OUT_BIT];
                port_dir_r <= wbyte[PORT_DIR_BIT];
            end
        end
    end

    // compare value, active and buffer
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            cmp_act_r <= CNT_BOTTOM;
            cmp_buf_r <= CNT_BOTTOM;
            pending_r <= 1'b0;
        end else begin
            if (wr_cmp && buffered) begin
                cmp_buf_r <= wbyte;
                pending_r <= 1'b1;
            end else if (wr_cmp) begin
                cmp_act_r <= wbyte;
                cmp_buf_r <= wbyte;
            end
            if (buffered && load_pt && pending_r && !wr_cmp) begin
                cmp_act_r <= cmp_buf_r;
                pending_r <= 1'b0;
            end
            if (!buffered && !wr_cmp) begin
                pending_r <= 1'b0;
            end
        end
    end

    // flags and match blocking
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ovf_flag_r <= 1'b0;
            cmp_flag_r <= 1'b0;
            block_r    <= 1'b0;
        end else begin
            // block held until next tick, even while stopped
            if (wr_cnt) begin
                block_r <= 1'b1;
            end else if (tick) begin
                block_r <= 1'b0;
            end
            // clear by write one or service, set wins
            if ((wr_flg && wbyte[FLG_OVF_BIT]) || OVF_ACK_I) begin
                ovf_flag_r <= 1'b0;
            end
            if ((wr_flg && wbyte[FLG_CMP_BIT]) || CMP_ACK_I) begin
                cmp_flag_r <= 1'b0;
            end
            if (ovf_ev) begin
                ovf_flag_r <= 1'b1;
            end
            // match registered, flag visible next tick cycle
            if (match_ev) begin
                cmp_flag_r <= 1'b1;
            end
        end
    end

    // read data
    wire [31:0] rmux = sel_ctrl ? {24'h0, 1'b0, ctrl_r.com, ctrl_r.wgm, ctrl_r.cs} :
                       sel_cnt  ? {24'h0, count} :
                       sel_cmp  ? {24'h0, buffered ? cmp_buf_r : cmp_act_r} :
                       sel_flg  ? {30'h0, cmp_flag_r, ovf_flag_r} :
                       sel_ien  ? {30'h0, cmp_irq_en_r, ovf_irq_en_r} :
                       sel_port ? {30'h0, port_dir_r, port_out_r} : 32'h0;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            rdata_r <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            rdata_r <= rmux;
        end
    end

    assign PRDATA_O     = rd ? rdata_r : 32'h0;
    assign PREADY_O     = 1'b1;
    assign PSLVERR_O    = access && !mapped;
    // override port output, direction stays with port
    assign PIN_OUT_O    = (ctrl_r.com != 2'h0) ? oc_state : port_out_r;
    assign PIN_OE_O     = port_dir_r;
    assign CLK_SRC_ON_O = (ctrl_r.cs != 3'h0);
    assign CMP_IRQ_O    = cmp_flag_r && cmp_irq_en_r;
    assign OVF_IRQ_O    = ovf_flag_r && ovf_irq_en_r;
endmodule

// ### dv/timer8_top_asserts.sv
// Purpose: port-level assertions for timer8_top
// Assumes: zero-wait apb slave, tick in clk domain
// Notes:   bound to every timer8_top instance
`timescale 1ns/1ns
module timer8_top_asserts
    import timer8_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        TICK_I,
    input  wire logic        OVF_ACK_I,
    input  wire logic        CMP_ACK_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PRDATA_O,
    input  wire logic        PREADY_O,
    input  wire logic        PSLVERR_O,
    input  wire logic        PIN_OE_O,
    input  wire logic        CLK_SRC_ON_O,
    input  wire logic        OVF_IRQ_O,
    input  wire logic        CMP_IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    wire rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;

    property p_stop;
        !CLK_SRC_ON_O && !wr_acc |=> !$rose(CMP_IRQ_O) && !$rose(OVF_IRQ_O);
    endproperty
    a_stop: assert property (p_stop) else $error("irq rose while stopped");
    property p_src;
        $past(RST_B_I) && $changed(CLK_SRC_ON_O) |-> $past(wr_acc && PADDR_I == OFS_CTRL);
    endproperty
    a_src: assert property (p_src) else $error("source flag moved without write");
    property p_cmp_rise;
        $rose(CMP_IRQ_O) |-> $past(TICK_I && CLK_SRC_ON_O) || $past(wr_acc);
    endproperty
    a_cmp_rise: assert property (p_cmp_rise) else $error("compare irq without tick");
    property p_cmp_ack;
        CMP_ACK_I && !TICK_I |=> !CMP_IRQ_O;
    endproperty
    a_cmp_ack: assert property (p_cmp_ack) else $error("compare ack ignored");
    property p_ovf_ack;
        OVF_ACK_I && !TICK_I |=> !OVF_IRQ_O;
    endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("overflow ack ignored");
    property p_dir;
        $past(RST_B_I) && $changed(PIN_OE_O) |-> $past(wr_acc && PADDR_I == OFS_PORT);
    endproperty
    a_dir: assert property (p_dir) else $error("pin enable moved without write");
    property p_rdata;
        !rd_acc |-> PRDATA_O == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside access");
    property p_err;
        PSEL_I && PENABLE_I && PADDR_I[1:0] == 2'h0 && PADDR_I <= OFS_PORT |-> PREADY_O && !PSLVERR_O;
    endproperty
    a_err: assert property (p_err) else $error("mapped access refused");
endmodule

bind timer8_top timer8_top_asserts u_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .TICK_I(TICK_I), .OVF_ACK_I(OVF_ACK_I),
    .CMP_ACK_I(CMP_ACK_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PIN_OE_O(PIN_OE_O), .CLK_SRC_ON_O(CLK_SRC_ON_O), .OVF_IRQ_O(OVF_IRQ_O), .CMP_IRQ_O(CMP_IRQ_O));

// ### dv/timer8_counter_compare_unit_tb_top.sv
// Purpose: self-checking bench for timer8_top
// Assumes: zero-wait apb, ticks made by the bench
// Notes:   expectations follow the counting rules
`timescale 1ns/1ns
module timer8_counter_compare_unit_tb_top
    import timer8_pkg::*;
;
    logic        clk, rst_b, tick, ovf_ack, cmp_ack, psel, pen, pwr;
    logic [7:0]  paddr, v;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, perr, err, pin_out, pin_oe, src_on, ovf_irq, cmp_irq;
    int          miscompares, num_checks, cycles, seed;

    timer8_top DUT (
        .CLK_I(clk), .RST_B_I(rst_b), .TICK_I(tick), .OVF_ACK_I(ovf_ack), .CMP_ACK_I(cmp_ack),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .PIN_OUT_O(pin_out),
        .PIN_OE_O(pin_oe), .CLK_SRC_ON_O(src_on), .OVF_IRQ_O(ovf_irq), .CMP_IRQ_O(cmp_irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // setup edge, then access until pready seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic ticks(input int n);
        @(posedge clk);
        tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
    endtask

    // ticks that carry an up-counter from c through max
    function automatic int to_max(input logic [7:0] c);
        return int'(CNT_MAX) - int'(c) + 1;
    endfunction

    task automatic pulse(input logic o);
        @(posedge clk);
        if (o) ovf_ack <= 1'b1;
        else cmp_ack <= 1'b1;
        @(posedge clk);
        ovf_ack <= 1'b0;
        cmp_ack <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        seed = 37999;
        {rst_b, tick, ovf_ack, cmp_ack, psel, pen, pwr} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(err), 32'h1);
        $display("reset values done");
        v = 8'($random(seed));
        apb(1'b1, OFS_COUNT, {24'h0, v});
        ticks(3);
        rchk(OFS_COUNT, {24'h0, v});
        chk(32'(src_on), 32'h0);
        $display("stopped counter done");
        apb(1'b1, OFS_IRQEN, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h01);
        apb(1'b1, OFS_COUNT, 32'hfe);
        ticks(2);
        rchk(OFS_COUNT, 32'h0);
        chk(32'(src_on), 32'h1);
        rchk(OFS_FLAGS, 32'h1);
        pulse(1'b1);
        chk(32'(ovf_irq), 32'h0);
        $display("overflow done");
        v = (8'($random(seed)) & 8'h7f) | 8'h01;
        apb(1'b1, OFS_CMP, {24'h0, v});
        apb(1'b1, OFS_COUNT, {24'h0, v});
        ticks(1);
        rchk(OFS_FLAGS, 32'h0);
        apb(1'b1, OFS_COUNT, {24'h0, v - 8'h1});
        ticks(1);
        rchk(OFS_FLAGS, 32'h0);
        ticks(1);
        rchk(OFS_FLAGS, 32'h2);
        chk(32'(cmp_irq), 32'h1);
        apb(1'b1, OFS_IRQEN, 32'h1);
        @(negedge clk);
        chk(32'(cmp_irq), 32'h0);
        apb(1'b1, OFS_IRQEN, 32'h3);
        pulse(1'b0);
        rchk(OFS_FLAGS, 32'h0);
        $display("compare match done");
        @(posedge clk);
        tick <= 1'b1;
        apb(1'b1, OFS_COUNT, 32'h80);
        tick <= 1'b0;
        rchk(OFS_COUNT, 32'h80);
        apb(1'b1, OFS_CTRL, 32'h11);
        apb(1'b1, OFS_COUNT, {24'h0, v - 8'h1});
        ticks(2);
        rchk(OFS_COUNT, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h09);
        apb(1'b1, OFS_COUNT, 32'hff);
        ticks(2);
        rchk(OFS_COUNT, 32'hfd);
        $display("mode sequences done");
        apb(1'b1, OFS_CTRL, 32'h11);
        apb(1'b1, OFS_CMP, 32'h10);
        apb(1'b1, OFS_CTRL, 32'h19);
        apb(1'b1, OFS_CMP, 32'h20);
        rchk(OFS_CMP, 32'h20);
        apb(1'b1, OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_COUNT, 32'h0f);
        ticks(2);
        rchk(OFS_FLAGS, 32'h2);
        ticks(to_max(8'h11));
        rchk(OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h11);
        rchk(OFS_CMP, 32'h20);
        $display("buffering done");
        apb(1'b1, OFS_CTRL, 32'h00);
        apb(1'b1, OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_PORT, 32'h3);
        @(negedge clk);
        chk({30'h0, pin_oe, pin_out}, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h20);
        @(negedge clk);
        chk(32'(pin_out), 32'h0);
        apb(1'b1, OFS_CTRL, 32'ha0);
        @(negedge clk);
        chk(32'(pin_out), 32'h1);
        rchk(OFS_FLAGS, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h00);
        apb(1'b1, OFS_CTRL, 32'h80);
        apb(1'b1, OFS_CTRL, 32'h38);
        @(negedge clk);
        chk(32'(pin_out), 32'h1);
        apb(1'b1, OFS_CTRL, 32'h28);
        @(negedge clk);
        chk(32'(pin_out), 32'h1);
        apb(1'b1, OFS_CTRL, 32'h51);
        apb(1'b1, OFS_COUNT, 32'h1f);
        ticks(2);
        @(negedge clk);
        chk(32'(pin_out), 32'h0);
        $display("output state done");
        close_out();
    end
endmodule
